// File: uvp_consts.svh
/*
  timing counts and geometry for the eprom host controller.
  assumes a 20 MHz clock (50 ns period); included by bare name.
*/
`ifndef UVP_CONSTS_SVH
`define UVP_CONSTS_SVH

`define UVP_CLK_NS          50
`define UVP_ADDR_W          11
`define UVP_DATA_W          8
// read timing in ns, slowest grade
`define UVP_ACC_NS          450
`define UVP_OE_NS           150
`define UVP_FLOAT_NS        130
`define UVP_ACC_CYC         ((`UVP_ACC_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_OE_CYC          ((`UVP_OE_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_PRE_OE_CYC      (`UVP_ACC_CYC - `UVP_OE_CYC)
`define UVP_FLOAT_CYC       ((`UVP_FLOAT_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
// program timing
`define UVP_SETUP_NS        2000
`define UVP_SETUP_CYC       ((`UVP_SETUP_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_PULSE_US        50000
`define UVP_PULSE_CYC       ((`UVP_PULSE_US * 1000) / `UVP_CLK_NS)
`define UVP_VERIFY_NS       120
`define UVP_VERIFY_CYC      ((`UVP_VERIFY_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_CNT_W           24

`endif

// File: uvp_eprom_model.sv
/*
  behavioural model of the 2048 x 8 uv eprom on the host's pins.
  assumes the bench resolves the shared data wire and feeds din.
*/
`timescale 1ns/1ps
module uvp_eprom_model #(
  parameter int ACC_NS = 450,
  parameter int OE_NS  = 150,
  parameter int PW_MIN = 45000000,
  parameter int PW_MAX = 55000000
) (
  // pins from the host
  input  wire logic [10:0] addr,
  input  wire logic        sel_n,
  input  wire logic        oe_n,
  input  wire logic        vpp,
  input  wire logic [7:0]  din,
  // data pins back
  output logic      [7:0]  dout,
  output logic             drive
);
  logic [7:0] mem [0:2047];
  realtime    t_addr, t_sel, t_oe, t_pulse;
  realtime    oe_ns;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    t_addr = 0;
    t_sel = 0;
    t_oe = 0;
    t_pulse = -1;
    dout = 8'h5a;
  end
  always @(addr) t_addr = $realtime;
  always @(negedge oe_n) t_oe = $realtime;
  // pulse counts only with supply high and enable high
  always @(posedge sel_n) t_pulse = (vpp && oe_n) ? $realtime : -1;
  always @(negedge sel_n) begin
    t_sel = $realtime;
    // too short or too long a pulse leaves the cell alone
    if (vpp && oe_n && t_pulse >= 0 && $realtime - t_pulse >= PW_MIN &&
        $realtime - t_pulse <= PW_MAX) begin
      mem[addr] = mem[addr] & din;
    end
    t_pulse = -1;
  end
  // drives only while both selected and enabled
  assign drive = !sel_n && !oe_n;
  // junk until access times run out, so early sampling is caught
  always #5 begin
    oe_ns = vpp ? 120 : OE_NS;
    if ($realtime - t_addr >= ACC_NS && $realtime - t_sel >= ACC_NS &&
        $realtime - t_oe >= oe_ns) begin
      dout = mem[addr];
    end else begin
      dout = ~dout;
    end
  end
endmodule

// File: uvp_host.sv
/*
  host controller that reads and programs a 2048 x 8 uv eprom by its pins.
  assumes one 20 MHz clock, a synchronous active-low reset, and an external
  level shifter that turns prog_supply_hi into the high program supply.
*/
`timescale 1ns/1ps
`include "uvp_consts.svh"

// Behaviour
// RQ1: device drives data only while select and output enable are both low
// RQ2: select high puts the device in standby
// RQ3: in standby outputs float whatever output enable does
// RQ4: data valid within address access time after stable address
// RQ5: data valid within output-enable access time after enable falls
// RQ6: output enable may lag select by access minus enable time
// RQ7: outputs float within float delay after enable or select rises
// RQ8: previous data held for zero minimum after any control change
// RQ9: erased bits read one; programming only clears chosen bits
// RQ10: enter program mode by raising supply with output enable high
// RQ11: present address and data, then one high pulse of 50 ms
// RQ12: each program pulse lasts between 45 and 55 ms
// RQ13: never hold select/program high steadily in program mode
// RQ14: locations may be programmed in any order, one pulse each
// RQ15: address, data, enable set 2 us before and held 2 us after
// RQ16: in verify, data within 120 ns of enable falling
// RQ17: never switch the supply while enable and select are both high
// RQ18: select low with supply high inhibits programming
// RQ19: pulses ignored unless supply high and output enable high
module uvp_host
  import uvp_pkg::*;
#(
  parameter int PULSE_CYC = `UVP_PULSE_CYC,
  parameter int SETUP_CYC = `UVP_SETUP_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // user request
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_write,
  input  wire logic [`UVP_ADDR_W-1:0] req_addr,
  input  wire logic [`UVP_DATA_W-1:0] req_wdata,
  // user answer
  output logic                        rsp_valid,
  output logic      [`UVP_DATA_W-1:0] rsp_rdata,
  output logic                        rsp_mismatch,
  // device pins
  output logic      [`UVP_ADDR_W-1:0] mem_addr,
  output logic                        select_and_program_pulse_n,
  output logic                        out_enable_n,
  output logic                        prog_supply_hi,
  input  wire logic [`UVP_DATA_W-1:0] mem_data_in,
  output logic      [`UVP_DATA_W-1:0] mem_data_out,
  output logic                        mem_data_oe_n
);
  localparam int ACC_CYC = `UVP_ACC_CYC;
  localparam int PRE_OE_CYC = `UVP_PRE_OE_CYC;
  localparam int FLOAT_CYC = `UVP_FLOAT_CYC;
  localparam int VER_CYC = `UVP_VERIFY_CYC;

  typedef struct packed {
    uvp_state_type                 state;
    logic [`UVP_CNT_W-1:0]         cnt;
    logic                          wr;
    logic [`UVP_ADDR_W-1:0]        addr;
    logic [`UVP_DATA_W-1:0]        wdata;
    logic                          sel_n;
    logic                          oe_n;
    logic                          vpp;
    logic                          drive;
    logic                          rsp;
    logic [`UVP_DATA_W-1:0]        rdata;
    logic                          mism;
  } uvp_host_type;

  uvp_host_type st_r;
  uvp_host_type st_nxt;
  logic [`UVP_DATA_W-1:0] data_sync;

  function automatic logic [`UVP_CNT_W-1:0] cyc(input int n);
    cyc = `UVP_CNT_W'(n);
  endfunction

  uvp_sync #(.W(`UVP_DATA_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (mem_data_in),
    .value  (data_sync)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp = 1'b0;
    st_nxt.cnt = st_r.cnt + cyc(1);
    case (st_r.state)
      UVP_IDLE: begin
        st_nxt.cnt = '0;
        if (req_valid) begin
          st_nxt.wr = req_write;
          st_nxt.addr = req_addr;
          st_nxt.wdata = req_wdata;
          if (req_write) begin
            // supply only moves with select low and enable high
            st_nxt.oe_n = 1'b1; // see RQ10
            st_nxt.sel_n = 1'b0; // see RQ17
            st_nxt.state = UVP_VPPUP;
          end else begin
            st_nxt.sel_n = 1'b0; // see RQ2
            st_nxt.state = UVP_RSETUP;
          end
        end
      end
      UVP_RSETUP: begin
        // enable lags select one cycle past access minus enable time, so enable time governs
        if (st_r.cnt == cyc(PRE_OE_CYC)) begin
          st_nxt.oe_n = 1'b0; // see RQ6
        end
        // data settles one cycle past access time (enable path);
        // three more cycles cover the synchroniser
        if (st_r.cnt == cyc(ACC_CYC + 4)) begin
          st_nxt.state = UVP_RDATA; // see RQ4
        end
      end
      UVP_RDATA: begin
        // sample after the access time plus the synchroniser latency
        st_nxt.rdata = data_sync; // see RQ5
        st_nxt.mism = 1'b0;
        st_nxt.rsp = 1'b1;
        st_nxt.sel_n = 1'b1; // see RQ3
        st_nxt.oe_n = 1'b1; // see RQ1
        st_nxt.cnt = '0;
        st_nxt.state = UVP_FLOAT;
      end
      UVP_FLOAT: begin
        // wait the float delay for the device to release the bus
        if (st_r.cnt == cyc(FLOAT_CYC)) begin
          st_nxt.vpp = 1'b0;
          st_nxt.state = UVP_IDLE; // see RQ7
        end
      end
      UVP_VPPUP: begin
        st_nxt.vpp = 1'b1; // see RQ10
        st_nxt.drive = 1'b1;
        st_nxt.cnt = '0;
        st_nxt.state = UVP_PSETUP;
      end
      UVP_PSETUP: begin
        if (st_r.cnt == cyc(SETUP_CYC)) begin
          st_nxt.sel_n = 1'b1; // see RQ15
          st_nxt.cnt = '0;
          st_nxt.state = UVP_PULSE;
        end
      end
      UVP_PULSE: begin
        // one bounded pulse per request, never a steady level
        if (st_r.cnt == cyc(PULSE_CYC - 1)) begin
          st_nxt.sel_n = 1'b0; // see RQ12
          st_nxt.cnt = '0;
          st_nxt.state = UVP_PHOLD; // see RQ13
        end
      end
      UVP_PHOLD: begin
        if (st_r.cnt == cyc(SETUP_CYC)) begin
          st_nxt.drive = 1'b0; // see RQ15
          st_nxt.oe_n = 1'b0; // see RQ16
          st_nxt.cnt = '0;
          st_nxt.state = UVP_VERIFY;
        end
      end
      UVP_VERIFY: begin
        if (st_r.cnt == cyc(VER_CYC + 3)) begin
          st_nxt.rdata = data_sync;
          // a programmed cell keeps zeros from before too, so any bit off from the data asked for is a mismatch
          st_nxt.mism = (data_sync != st_r.wdata); // see RQ9
          st_nxt.rsp = 1'b1;
          st_nxt.oe_n = 1'b1;
          st_nxt.cnt = '0;
          st_nxt.state = UVP_FLOAT;
        end
      end
      default: begin
        st_nxt.state = UVP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r.state <= UVP_IDLE;
      st_r.cnt <= '0;
      st_r.wr <= 1'b0;
      st_r.addr <= '0;
      st_r.wdata <= '0;
      st_r.sel_n <= 1'b1;
      st_r.oe_n <= 1'b1;
      st_r.vpp <= 1'b0;
      st_r.drive <= 1'b0;
      st_r.rsp <= 1'b0;
      st_r.rdata <= '0;
      st_r.mism <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // any order of addresses is accepted, one pulse each
  assign req_ready = (st_r.state == UVP_IDLE); // see RQ14
  assign rsp_valid = st_r.rsp;
  assign rsp_rdata = st_r.rdata;
  assign rsp_mismatch = st_r.mism;
  assign mem_addr = st_r.addr;
  assign select_and_program_pulse_n = st_r.sel_n;
  assign out_enable_n = st_r.oe_n;
  assign prog_supply_hi = st_r.vpp;
  assign mem_data_out = st_r.wdata;
  assign mem_data_oe_n = ~st_r.drive;

  int pulse_len_r;
  always_ff @(posedge clk) begin
    if (!resetn || st_r.sel_n == 1'b0 || !st_r.vpp) begin
      pulse_len_r <= 0;
    end else begin
      pulse_len_r <= pulse_len_r + 1;
    end
  end

  pulse_bounded_a: assert property (@(posedge clk) disable iff (!resetn)
    pulse_len_r <= PULSE_CYC) else $error("program pulse too long"); // see RQ12
  pulse_oe_high_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r.vpp && st_r.sel_n) |-> st_r.oe_n)
    else $error("enable low during pulse"); // see RQ19
  vpp_switch_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(st_r.vpp) |-> !($past(st_r.oe_n) && $past(st_r.sel_n)))
    else $error("supply switched with both high"); // see RQ17
  data_setup_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(st_r.sel_n) && st_r.vpp |-> $past(st_r.drive, SETUP_CYC))
    else $error("data not set up before pulse"); // see RQ15
  data_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(st_r.sel_n) && st_r.vpp |=> st_r.drive [*8])
    else $error("data not held after pulse"); // see RQ15
  read_oe_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(st_r.oe_n) && !st_r.vpp |-> ##1 !st_r.oe_n [*3])
    else $error("enable too short on read"); // see RQ5
  no_contend_a: assert property (@(posedge clk) disable iff (!resetn)
    !st_r.oe_n |-> !st_r.drive)
    else $error("bus contention"); // see RQ1
  ready_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    rsp_valid |=> ##[1:10] req_ready)
    else $error("controller did not return to idle"); // see RQ14
endmodule

// File: uvp_host_test.sv
/*
  self-checking bench for the eprom host controller.
  assumes the eprom model and a 20 MHz clock; short program pulse.
*/
`timescale 1ns/1ps
`include "uvp_consts.svh"
module uvp_host_test;
  localparam int PULSE = 50;
  localparam int SETUP = 40;
  logic        clk = 0, resetn = 0, req_valid = 0, req_write = 0;
  logic [10:0] req_addr = '0;
  logic [7:0]  req_wdata = '0, rsp_rdata, mem_data_out, dev_q, pat = 8'h96;
  logic [10:0] mem_addr;
  logic        req_ready, rsp_valid, rsp_mismatch, sel_n, out_enable_n;
  logic        prog_supply_hi, mem_data_oe_n, dev_drive, psel, pvpp;
  logic [7:0]  bus;
  logic [20:0] pv;
  int          num_errors = 0, checks = 0, cyc = 0, pw = 0, stab = 0;
  int          since_fall = 1000;
  // floating wire shows a changing pattern, never the last value
  assign bus = !mem_data_oe_n ? mem_data_out : dev_drive ? dev_q : pat;
  always #25 clk = ~clk;
  uvp_host #(.PULSE_CYC(PULSE), .SETUP_CYC(SETUP)) DUT (
    .clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_mismatch(rsp_mismatch), .mem_addr(mem_addr),
    .select_and_program_pulse_n(sel_n), .out_enable_n(out_enable_n),
    .prog_supply_hi(prog_supply_hi), .mem_data_in(bus),
    .mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n));
  uvp_eprom_model #(.PW_MIN(PULSE * 45), .PW_MAX(PULSE * 55)) dev (
    .addr(mem_addr), .sel_n(sel_n), .oe_n(out_enable_n),
    .vpp(prog_supply_hi), .din(bus), .dout(dev_q), .drive(dev_drive));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // pin-level watch of the programming sequence the host produces
  always @(posedge clk) begin
    pat <= ~pat + 8'h01;
    psel <= sel_n;
    pvpp <= prog_supply_hi;
    pv <= {mem_addr, mem_data_out, out_enable_n, mem_data_oe_n};
    since_fall <= since_fall + 1;
    stab <= (pv == {mem_addr, mem_data_out, out_enable_n, mem_data_oe_n})
            ? stab + 1 : 0;
    pw <= (sel_n && prog_supply_hi) ? pw + 1 : 0;
    if (resetn === 1'b1) begin
      if (!psel && sel_n && prog_supply_hi) begin
        chk(16'(stab >= SETUP - 1), 16'h0001);
        chk({15'h0, out_enable_n}, 16'h0001);
      end
      if (psel && !sel_n && pvpp) begin
        chk(16'(pw), 16'(PULSE));
        since_fall <= 0;
      end
      if (pv != {mem_addr, mem_data_out, out_enable_n, mem_data_oe_n} &&
          since_fall < SETUP - 1) chk(16'h0000, 16'h0001);
      if (prog_supply_hi !== pvpp)
        chk({15'h0, sel_n & out_enable_n}, 16'h0000);
    end
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic do_req(input logic w, input logic [10:0] a,
                        input logic [7:0] d, input logic [7:0] q_exp,
                        input logic m_exp);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 400);
    chk({15'h0, req_ready}, 16'h0001);
    req_valid <= 1'b0;
    n = 0;
    do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 400);
    chk({15'h0, rsp_valid}, 16'h0001);
    chk({8'h00, rsp_rdata}, {8'h00, q_exp});
    chk({15'h0, rsp_mismatch}, {15'h0, m_exp});
  endtask
  task automatic t_reset();
    chk({12'h0, sel_n, out_enable_n, prog_supply_hi, mem_data_oe_n},
        16'h000d);
    chk({14'h0, req_ready, dev_drive}, 16'h0002);
  endtask
  task automatic t_read_erased();
    do_req(1'b0, 11'h000, 8'h00, 8'hff, 1'b0);
    do_req(1'b0, 11'h7ff, 8'h00, 8'hff, 1'b0);
  endtask
  task automatic t_prog_any_order();
    do_req(1'b1, 11'h5a3, 8'ha5, 8'ha5, 1'b0);
    do_req(1'b1, 11'h012, 8'h3c, 8'h3c, 1'b0);
    do_req(1'b0, 11'h5a3, 8'h00, 8'ha5, 1'b0);
    do_req(1'b0, 11'h012, 8'h00, 8'h3c, 1'b0);
  endtask
  task automatic t_prog_clear_only();
    do_req(1'b1, 11'h012, 8'hc3, 8'h00, 1'b1);
    do_req(1'b0, 11'h013, 8'h00, 8'hff, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_read_erased();
    t_prog_any_order();
    t_prog_clear_only();
    summarize();
  end
endmodule

// File: uvp_pkg.sv
/*
  types for the eprom host controller.
  assumes the constants header is available.
*/
package uvp_pkg;
  typedef enum logic [8:0] {
    UVP_IDLE   = 9'b0_0000_0001,
    UVP_RSETUP = 9'b0_0000_0010,
    UVP_RDATA  = 9'b0_0000_0100,
    UVP_FLOAT  = 9'b0_0000_1000,
    UVP_VPPUP  = 9'b0_0001_0000,
    UVP_PSETUP = 9'b0_0010_0000,
    UVP_PULSE  = 9'b0_0100_0000,
    UVP_PHOLD  = 9'b0_1000_0000,
    UVP_VERIFY = 9'b1_0000_0000
  } uvp_state_type;
endpackage

// File: uvp_sync.sv
/*
  three-stage synchroniser for the returning data bus.
  assumes the input comes from the device pins, outside the clock domain.
*/
`timescale 1ns/1ps
module uvp_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // pins in, settled value out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] value
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } uvp_sync_type;
  uvp_sync_type st_r;
  uvp_sync_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // a change counts once stage two and three agree
    if (st_r.s2 == st_r.s3) begin
      st_nxt.val = st_r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.val;
endmodule
